// file: pkg/css_pkg.sv
/*
  constants, field layout, state codes and helper functions of the clock switch and slew
  controller. assumes a 32-bit register port with one aligned word per register.
*/
// How it works
// - unlock opens only after first key then second key in consecutive key writes
// - any non-key value written to the key register locks again
// - lock stays open until software locks it, never after a switch
// - one unlock opens every guarded register; only oscillator control is guarded
// - software sets next source then request; hardware clears request on completion
// - a source that never becomes ready leaves request set and old source running
// - a PLL source is not taken before the PLL reports lock
// - a crystal source waits its start-up interval before being taken
// - sleep does not cancel a pending switch; it completes on wake before code runs
// - slewing only for software switches and wake; hardware skips it except two-speed
// - 4-bit final divider, 3-bit step count, read-only busy flag
// - software switch: up enable slews toward faster clocks, down enable toward slower ones; two-speed slews with either enable set
// - slewing down: busy, divide by two, wait source, double every four clocks
// - end of down slew: take slower source, load final divider, clear busy
// - slewing up: busy, wait source, switch at target, halve every four clocks
// - secondary oscillator runs when enabled or used by the CPU
// - clearing the enable does not stop it while it is the clock source
// - an enabled secondary oscillator keeps running in sleep
// - secondary oscillator enable is writable only while the lock is open
// - request for the current source is redundant: request cleared at once
// - completion copies next source into current source and clears request; an up switch loads the source latched at the request instead
package css_pkg;

  // ----------------------------------------------------------------
  // register offsets and keys
  // ----------------------------------------------------------------
  localparam logic [7:0]  CSS_KEY_OFS   = 8'h00;
  localparam logic [7:0]  CSS_OSC_OFS   = 8'h04;
  localparam logic [7:0]  CSS_SLEW_OFS  = 8'h08;
  localparam logic [31:0] CSS_KEY_FIRST = 32'hAA996655;
  localparam logic [31:0] CSS_KEY_SECOND = 32'h556699AA;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CSS_REQ_POS   = 0;
  localparam int CSS_SOSC_POS  = 1;
  localparam int CSS_NXT_POS   = 8;
  localparam int CSS_CUR_POS   = 12;
  localparam int CSS_BUSY_POS  = 0;
  localparam int CSS_DN_POS    = 1;
  localparam int CSS_UP_POS    = 2;
  localparam int CSS_STEPS_POS = 8;
  localparam int CSS_FINAL_POS = 16;

  // ----------------------------------------------------------------
  // reset values and source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CSS_SRC_FRC   = 3'h0;
  localparam logic [2:0] CSS_SRC_SPLL  = 3'h1;
  localparam logic [2:0] CSS_SRC_POSC  = 3'h2;
  localparam logic [2:0] CSS_SRC_SOSC  = 3'h4;
  localparam logic [2:0] CSS_SRC_LOW_POWER_RC_OSCILLATOR  = 3'h5;
  localparam logic [2:0] CSS_RST_SRC   = CSS_SRC_FRC;
  localparam logic [3:0] CSS_RST_FINAL = 4'h1;
  localparam logic [2:0] CSS_RST_STEPS = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CSS_CLK_NS     = 8;
  localparam int         CSS_OST_NS     = 1000;
  localparam logic [7:0] CSS_OST_CYC    = 8'((CSS_OST_NS + CSS_CLK_NS - 1) / CSS_CLK_NS);
  localparam logic [7:0] CSS_STEP_LAST  = 8'h03;

  typedef enum logic [4:0] {
    CSS_IDLE    = 5'b00001,
    CSS_WAITSRC = 5'b00010,
    CSS_STARTUP = 5'b00100,
    CSS_SLEWDN  = 5'b01000,
    CSS_SLEWUP  = 5'b10000
  } css_state_t;

  // speed rank: higher means faster
  function automatic logic [2:0] css_rank(input logic [2:0] src);
    unique case (src)
      CSS_SRC_SPLL: css_rank = 3'h4;
      CSS_SRC_POSC: css_rank = 3'h3;
      CSS_SRC_SOSC: css_rank = 3'h1;
      CSS_SRC_LOW_POWER_RC_OSCILLATOR: css_rank = 3'h0;
      default:      css_rank = 3'h2;
    endcase
  endfunction : css_rank

  function automatic logic css_uses_pll(input logic [2:0] src);
    css_uses_pll = (src == CSS_SRC_SPLL);
  endfunction : css_uses_pll

  function automatic logic css_is_xtal(input logic [2:0] src);
    css_is_xtal = (src == CSS_SRC_POSC) || (src == CSS_SRC_SOSC);
  endfunction : css_is_xtal

  // final divider times steps; zero fields count as one so the slew always ends
  function automatic logic [7:0] css_target(input logic [3:0] fin, input logic [2:0] st);
    logic [3:0] f;
    logic [2:0] s;
    f = (fin == 4'h0) ? 4'h1 : fin;
    s = (st == 3'h0) ? 3'h1 : st;
    css_target = 8'(f) * 8'(s);
  endfunction : css_target

endpackage : css_pkg

// file: src/css_clock_switch.sv
/*
  clock switch and slew controller: key lock, switch request, source wait, divider slewing
  and secondary oscillator control. assumes source ready and PLL lock arrive as raw
  asynchronous levels and that inSleep comes from logic on sys_clk.
*/
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module css_clock_switch
  import css_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic [7:0]  srcReadyPin,
  input  wire logic        pllLockPin,
  input  wire logic        inSleep,
  input  wire logic        hwSwitch,
  input  wire logic [2:0]  hwSrc,
  input  wire logic        hwTwoSpeed,
  output logic      [2:0]  coreSrcSel,
  output logic      [7:0]  coreDivider,
  output logic      [7:0]  srcEnable,
  output logic             soscRun,
  output logic             protWriteOpen,
  output logic             slewBusy,
  output logic             cpuHold
);

  typedef struct packed {
    logic [7:0] rdyS1;
    logic [7:0] rdyS2;
    logic [7:0] rdyS3;
    logic [7:0] rdyF;
    logic       pllS1;
    logic       pllS2;
    logic       pllS3;
    logic       pllF;
    logic       unlocked;
    logic       keyArmed;
    logic       oscReq;
    logic       secondary_osc_enable;
    logic [2:0] nxtSrc;
    logic [2:0] curSrc;
    logic [2:0] tgtSrc;
    logic [3:0] finalDiv;
    logic [2:0] slewSteps;
    logic       slew_up_enable;
    logic       slew_down_enable;
    logic       busy;
    logic       useSlew;
    logic       slowDir;
    logic       swInit;
    logic       sleptPend;
    logic [7:0] div;
    logic [7:0] cnt;
    css_state_t state;
    logic [31:0] rdata;
  } css_reg_t;

  css_reg_t st_ff;
  css_reg_t nxt_st;

  logic [7:0] tgtDiv;
  logic       srcOk;
  logic       keyWr;

  assign tgtDiv = css_target(st_ff.finalDiv, st_ff.slewSteps);
  assign srcOk  = st_ff.rdyF[st_ff.tgtSrc] && (!css_uses_pll(st_ff.tgtSrc) || st_ff.pllF);
  assign keyWr  = regWr && (regAddr == CSS_KEY_OFS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // three-stage sampling; a change counts once stages two and three agree
    nxt_st.rdyS1 = srcReadyPin;
    nxt_st.rdyS2 = st_ff.rdyS1;
    nxt_st.rdyS3 = st_ff.rdyS2;
    nxt_st.pllS1 = pllLockPin;
    nxt_st.pllS2 = st_ff.pllS1;
    nxt_st.pllS3 = st_ff.pllS2;
    for (int i = 0; i < 8; i++) begin
      if (st_ff.rdyS2[i] == st_ff.rdyS3[i]) begin
        nxt_st.rdyF[i] = st_ff.rdyS3[i];
      end
    end
    if (st_ff.pllS2 == st_ff.pllS3) begin
      nxt_st.pllF = st_ff.pllS3;
    end

    // key sequence; any other register access in between breaks the pair
    if ((regWr || regRd) && !keyWr) begin
      nxt_st.keyArmed = 1'b0;
    end
    if (keyWr) begin
      if (regWrData == CSS_KEY_FIRST) begin
        nxt_st.keyArmed = 1'b1;
      end else if (regWrData == CSS_KEY_SECOND) begin
        nxt_st.keyArmed = 1'b0;
        if (st_ff.keyArmed) begin
          nxt_st.unlocked = 1'b1;
        end
      end else begin
        nxt_st.keyArmed = 1'b0;
        nxt_st.unlocked = 1'b0;
      end
    end

    // guarded oscillator control writes
    if (regWr && (regAddr == CSS_OSC_OFS) && st_ff.unlocked) begin
      nxt_st.oscReq = regWrData[CSS_REQ_POS];
      nxt_st.secondary_osc_enable = regWrData[CSS_SOSC_POS];
      nxt_st.nxtSrc = regWrData[CSS_NXT_POS +: 3];
    end
    if (regWr && (regAddr == CSS_SLEW_OFS)) begin
      nxt_st.slew_down_enable      = regWrData[CSS_DN_POS];
      nxt_st.slew_up_enable      = regWrData[CSS_UP_POS];
      nxt_st.slewSteps = regWrData[CSS_STEPS_POS +: 3];
      nxt_st.finalDiv  = regWrData[CSS_FINAL_POS +: 4];
    end

    // read data, one cycle after the strobe
    nxt_st.rdata = 32'h0;
    if (regRd) begin
      unique case (regAddr)
        CSS_OSC_OFS: begin
          nxt_st.rdata[CSS_REQ_POS]       = st_ff.oscReq;
          nxt_st.rdata[CSS_SOSC_POS]      = st_ff.secondary_osc_enable;
          nxt_st.rdata[CSS_NXT_POS +: 3]  = st_ff.nxtSrc;
          nxt_st.rdata[CSS_CUR_POS +: 3]  = st_ff.curSrc;
        end
        CSS_SLEW_OFS: begin
          nxt_st.rdata[CSS_BUSY_POS]        = st_ff.busy;
          nxt_st.rdata[CSS_DN_POS]          = st_ff.slew_down_enable;
          nxt_st.rdata[CSS_UP_POS]          = st_ff.slew_up_enable;
          nxt_st.rdata[CSS_STEPS_POS +: 3]  = st_ff.slewSteps;
          nxt_st.rdata[CSS_FINAL_POS +: 4]  = st_ff.finalDiv;
        end
        default: nxt_st.rdata = 32'h0;
      endcase
    end

    // a switch pending at sleep entry stalls the core after wake until done
    if (inSleep && (st_ff.oscReq || (st_ff.state != CSS_IDLE))) begin
      nxt_st.sleptPend = 1'b1;
    end else if (!st_ff.oscReq && (st_ff.state == CSS_IDLE)) begin
      nxt_st.sleptPend = 1'b0;
    end

    // switch sequencer; the core clock is stopped in sleep so the sequencer waits
    if (!inSleep) begin
      unique case (st_ff.state)
        CSS_IDLE: begin
          if (hwSwitch && (hwSrc != st_ff.curSrc)) begin
            nxt_st.tgtSrc  = hwSrc;
            nxt_st.swInit  = 1'b0;
            nxt_st.slowDir = css_rank(hwSrc) < css_rank(st_ff.curSrc);
            nxt_st.useSlew = hwTwoSpeed && (st_ff.curSrc == CSS_SRC_FRC) &&
                             (st_ff.slew_up_enable || st_ff.slew_down_enable);
            nxt_st.cnt     = 8'h00;
            nxt_st.state   = CSS_WAITSRC;
          end else if (st_ff.oscReq) begin
            if (st_ff.nxtSrc == st_ff.curSrc) begin
              nxt_st.oscReq = 1'b0;
            end else begin
              nxt_st.tgtSrc  = st_ff.nxtSrc;
              nxt_st.swInit  = 1'b1;
              nxt_st.slowDir = css_rank(st_ff.nxtSrc) < css_rank(st_ff.curSrc);
              nxt_st.useSlew = (css_rank(st_ff.nxtSrc) < css_rank(st_ff.curSrc)) ?
                               st_ff.slew_down_enable : st_ff.slew_up_enable;
              nxt_st.cnt     = 8'h00;
              nxt_st.state   = CSS_WAITSRC;
            end
          end
          if (nxt_st.state == CSS_WAITSRC && nxt_st.useSlew) begin
            nxt_st.busy = 1'b1;
            if (nxt_st.slowDir) begin
              nxt_st.div = 8'h02;
            end
          end
        end
        CSS_WAITSRC: begin
          // stays here while the source is absent: request stays set, old source runs
          if (srcOk) begin
            nxt_st.cnt   = 8'h00;
            nxt_st.state = css_is_xtal(st_ff.tgtSrc) ? CSS_STARTUP : CSS_SLEWDN;
            if (!css_is_xtal(st_ff.tgtSrc) && !st_ff.slowDir) begin
              nxt_st.state = CSS_SLEWUP;
            end
          end
        end
        CSS_STARTUP: begin
          nxt_st.cnt = st_ff.cnt + 8'h01;
          if (st_ff.cnt == CSS_OST_CYC - 8'h01) begin
            nxt_st.cnt   = 8'h00;
            nxt_st.state = st_ff.slowDir ? CSS_SLEWDN : CSS_SLEWUP;
          end
        end
        CSS_SLEWDN: begin
          nxt_st.cnt = st_ff.cnt + 8'h01;
          if (!st_ff.useSlew || (st_ff.cnt == CSS_STEP_LAST)) begin
            nxt_st.cnt = 8'h00;
            if (!st_ff.useSlew || st_ff.div >= tgtDiv) begin
              nxt_st.curSrc = st_ff.tgtSrc;
              nxt_st.div    = {4'h0, st_ff.finalDiv};
              nxt_st.busy   = 1'b0;
              nxt_st.state  = CSS_IDLE;
              if (st_ff.swInit) begin
                nxt_st.oscReq = 1'b0;
                nxt_st.curSrc = st_ff.nxtSrc;
              end
            end else begin
              nxt_st.div = ({st_ff.div[6:0], 1'b0} > tgtDiv) ? tgtDiv :
                           {st_ff.div[6:0], 1'b0};
            end
          end
        end
        CSS_SLEWUP: begin
          nxt_st.cnt = st_ff.cnt + 8'h01;
          if (st_ff.cnt == 8'h00 && st_ff.curSrc != st_ff.tgtSrc) begin
            nxt_st.curSrc = st_ff.tgtSrc;
            nxt_st.div    = st_ff.useSlew ? tgtDiv : {4'h0, st_ff.finalDiv};
          end
          if (!st_ff.useSlew || (st_ff.cnt == CSS_STEP_LAST)) begin
            nxt_st.cnt = 8'h00;
            if (!st_ff.useSlew || (st_ff.div >> 1) <= {4'h0, st_ff.finalDiv}) begin
              nxt_st.curSrc = st_ff.tgtSrc;
              nxt_st.div    = {4'h0, st_ff.finalDiv};
              nxt_st.busy   = 1'b0;
              nxt_st.state  = CSS_IDLE;
              if (st_ff.swInit) begin
                nxt_st.oscReq = 1'b0;
              end
            end else begin
              nxt_st.div = st_ff.div >> 1;
            end
          end
        end
        default: nxt_st.state = CSS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff           <= '0;
      st_ff.curSrc    <= CSS_RST_SRC;
      st_ff.nxtSrc    <= CSS_RST_SRC;
      st_ff.tgtSrc    <= CSS_RST_SRC;
      st_ff.finalDiv  <= CSS_RST_FINAL;
      st_ff.slewSteps <= CSS_RST_STEPS;
      st_ff.div       <= {4'h0, CSS_RST_FINAL};
      st_ff.state     <= CSS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData     = st_ff.rdata;
  assign coreSrcSel    = st_ff.curSrc;
  assign coreDivider   = st_ff.div;
  assign protWriteOpen = st_ff.unlocked;
  assign slewBusy      = st_ff.busy;
  assign cpuHold       = st_ff.sleptPend && !inSleep;
  // sleep does not gate the enable, so an enabled oscillator keeps running
  assign soscRun       = st_ff.secondary_osc_enable || (st_ff.curSrc == CSS_SRC_SOSC) ||
                         ((st_ff.state != CSS_IDLE) && (st_ff.tgtSrc == CSS_SRC_SOSC));

  always_comb begin
    srcEnable = 8'h00;
    srcEnable[st_ff.curSrc] = 1'b1;
    if (st_ff.state != CSS_IDLE) begin
      srcEnable[st_ff.tgtSrc] = 1'b1;
    end
    srcEnable[CSS_SRC_SOSC] = soscRun;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence keyPair;
    (keyWr && regWrData == CSS_KEY_FIRST) ##1 (keyWr && regWrData == CSS_KEY_SECOND);
  endsequence

  sequence slewTick;
    (st_ff.state == CSS_SLEWDN) && st_ff.useSlew && (st_ff.cnt == CSS_STEP_LAST) && !inSleep;
  endsequence

  unlock_seq_a: assert property (keyPair |=> protWriteOpen)
    else $error("key pair did not unlock");
  relock_a: assert property (keyWr && regWrData != CSS_KEY_FIRST &&
                             regWrData != CSS_KEY_SECOND |=> !protWriteOpen)
    else $error("non-key write did not lock");
  guard_write_a: assert property (regWr && regAddr == CSS_OSC_OFS && !protWriteOpen
                                  |=> $stable(st_ff.secondary_osc_enable) && $stable(st_ff.nxtSrc))
    else $error("locked oscillator control changed");
  redundant_req_a: assert property (st_ff.state == CSS_IDLE && st_ff.oscReq && !hwSwitch &&
                                    st_ff.nxtSrc == coreSrcSel && !inSleep
                                    && !(regWr && regAddr == CSS_OSC_OFS)
                                    |=> !st_ff.oscReq)
    else $error("redundant request not cleared");
  pll_wait_a: assert property (st_ff.state == CSS_WAITSRC && css_uses_pll(st_ff.tgtSrc) &&
                               !st_ff.pllF |=> st_ff.state == CSS_WAITSRC &&
                               $stable(coreSrcSel))
    else $error("switch left source wait without PLL lock");
  sosc_hold_a: assert property (coreSrcSel == CSS_SRC_SOSC |-> soscRun)
    else $error("secondary oscillator stopped while in use");
  busy_state_a: assert property (slewBusy |-> st_ff.state != CSS_IDLE)
    else $error("busy set outside a slew");
  slew_step_a: assert property (slewTick ##0 (st_ff.div < tgtDiv)
                                |=> coreDivider == $past(st_ff.div) * 2 ||
                                coreDivider == $past(tgtDiv))
    else $error("down slew step wrong");
  xtal_wait_a: assert property (st_ff.state == CSS_WAITSRC && css_is_xtal(st_ff.tgtSrc) &&
                                srcOk && !inSleep |=> st_ff.state == CSS_STARTUP)
    else $error("crystal taken without start-up wait");

endmodule : css_clock_switch

// file: bench/css_clock_switch_tb.sv
/*
  self-checking bench of the clock switch and slew controller: key lock, switch handshake,
  source waits, slewing, sleep and secondary oscillator control.
  assumes the register map and source codes of css_pkg and one 125 MHz clock.
*/
`timescale 1ns/10ps
module testbench
  import css_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        sys_clk, arst_n, regWr, regRd, pllLockPin, inSleep, hwSwitch, hwTwoSpeed;
  logic [7:0]  regAddr, srcReadyPin, coreDivider, srcEnable, maxDiv;
  logic [31:0] regWrData, regRdData, rdVal, lockVal;
  logic [2:0]  hwSrc, coreSrcSel;
  logic        soscRun, protWriteOpen, slewBusy, cpuHold, busySeen;
  logic [3:0]  fin;
  int          fails, nTests, n;

  css_clock_switch i_css_clock_switch (
    .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcReadyPin(srcReadyPin),
    .pllLockPin(pllLockPin), .inSleep(inSleep), .hwSwitch(hwSwitch), .hwSrc(hwSrc),
    .hwTwoSpeed(hwTwoSpeed), .coreSrcSel(coreSrcSel), .coreDivider(coreDivider),
    .srcEnable(srcEnable), .soscRun(soscRun), .protWriteOpen(protWriteOpen),
    .slewBusy(slewBusy), .cpuHold(cpuHold)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // slew trace: largest divider seen while busy
  always @(posedge sys_clk) begin
    if (slewBusy === 1'b1) begin
      busySeen <= 1'b1;
      if (coreDivider > maxDiv) maxDiv <= coreDivider;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] oscWord(logic [2:0] cur, logic [2:0] nxt, logic so, logic rq);
    oscWord = (32'(cur) << CSS_CUR_POS) | (32'(nxt) << CSS_NXT_POS)
            | (32'(so) << CSS_SOSC_POS) | (32'(rq) << CSS_REQ_POS);
  endfunction : oscWord

  function automatic logic [31:0] slewWord(logic [3:0] f, logic [2:0] st, logic up, logic dn);
    slewWord = (32'(f) << CSS_FINAL_POS) | (32'(st) << CSS_STEPS_POS)
             | (32'(up) << CSS_UP_POS) | (32'(dn) << CSS_DN_POS);
  endfunction : slewWord

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
  endtask : rd

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : cyc

  // both keys on consecutive edges, so the pair is truly back to back
  task automatic unlock;
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= CSS_KEY_OFS;
    regWrData <= CSS_KEY_FIRST;
    @(posedge sys_clk);
    regWrData <= CSS_KEY_SECOND;
    @(posedge sys_clk);
    regWr <= 1'b0;
    cyc(1);
  endtask : unlock

  // next source first, then the request, as software must
  task automatic sw(input logic [2:0] cur, input logic [2:0] nxt, input logic so);
    busySeen = 1'b0;
    maxDiv   = 8'h00;
    wr(CSS_OSC_OFS, oscWord(cur, nxt, so, 1'b0));
    wr(CSS_OSC_OFS, oscWord(cur, nxt, so, 1'b1));
  endtask : sw

  task automatic hwSw(input logic [2:0] s, input logic two);
    busySeen = 1'b0;
    @(posedge sys_clk);
    hwSwitch   <= 1'b1;
    hwSrc      <= s;
    hwTwoSpeed <= two;
    @(posedge sys_clk);
    hwSwitch <= 1'b0;
  endtask : hwSw

  task automatic waitSrc(input logic [2:0] s, input int lim);
    n = 0;
    while (coreSrcSel !== s && n < lim) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask : waitSrc

  task automatic summarize;
    if (fails == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {arst_n, regWr, regRd, pllLockPin, inSleep, hwSwitch, hwTwoSpeed, busySeen} = 8'h00;
    {regAddr, regWrData, hwSrc, maxDiv, fails, nTests} = '0;
    srcReadyPin = 8'h21;
    void'($urandom(33));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    cyc(1);
    check(coreSrcSel, CSS_RST_SRC);
    check(protWriteOpen, 1'b0);
    wr(CSS_KEY_OFS, CSS_KEY_SECOND);
    cyc(1);
    check(protWriteOpen, 1'b0);
    wr(CSS_KEY_OFS, CSS_KEY_FIRST);
    rd(CSS_OSC_OFS);
    wr(CSS_KEY_OFS, CSS_KEY_SECOND);
    cyc(1);
    check(protWriteOpen, 1'b0);
    wr(CSS_OSC_OFS, oscWord(3'h0, 3'h0, 1'b1, 1'b0));
    rd(CSS_OSC_OFS);
    check(rdVal, oscWord(3'h0, 3'h0, 1'b0, 1'b0));
    check(soscRun, 1'b0);
    unlock;
    check(protWriteOpen, 1'b1);
    wr(8'h0C, $urandom);
    wr(CSS_OSC_OFS, oscWord(3'h0, CSS_SRC_LOW_POWER_RC_OSCILLATOR, 1'b0, 1'b0));
    rd(CSS_OSC_OFS);
    check(rdVal, oscWord(3'h0, CSS_SRC_LOW_POWER_RC_OSCILLATOR, 1'b0, 1'b0));
    lockVal = $urandom;
    if (lockVal == CSS_KEY_FIRST || lockVal == CSS_KEY_SECOND) lockVal = 32'h33333333;
    wr(CSS_KEY_OFS, lockVal);
    cyc(1);
    check(protWriteOpen, 1'b0);
    unlock;
    wr(CSS_OSC_OFS, oscWord(3'h0, 3'h0, 1'b1, 1'b0));
    cyc(1);
    check(soscRun, 1'b1);
    // redundant request
    sw(3'h0, 3'h0, 1'b1);
    rd(CSS_OSC_OFS);
    check(rdVal, oscWord(3'h0, 3'h0, 1'b1, 1'b0));
    // plain switch down with no slew enabled
    fin = 4'($urandom_range(15, 1));
    wr(CSS_SLEW_OFS, slewWord(fin, 3'h2, 1'b0, 1'b0));
    sw(3'h0, CSS_SRC_LOW_POWER_RC_OSCILLATOR, 1'b0);
    waitSrc(CSS_SRC_LOW_POWER_RC_OSCILLATOR, 50);
    check(busySeen, 1'b0);
    check(coreDivider, 32'(fin));
    rd(CSS_OSC_OFS);
    check(rdVal, oscWord(CSS_SRC_LOW_POWER_RC_OSCILLATOR, CSS_SRC_LOW_POWER_RC_OSCILLATOR, 1'b0, 1'b0));
    check(protWriteOpen, 1'b1);
    // absent crystal, then start-up wait
    sw(CSS_SRC_LOW_POWER_RC_OSCILLATOR, CSS_SRC_POSC, 1'b0);
    cyc(200);
    check(coreSrcSel, CSS_SRC_LOW_POWER_RC_OSCILLATOR);
    rd(CSS_OSC_OFS);
    check(rdVal, oscWord(CSS_SRC_LOW_POWER_RC_OSCILLATOR, CSS_SRC_POSC, 1'b0, 1'b1));
    srcReadyPin <= 8'h25;
    waitSrc(CSS_SRC_POSC, 300);
    check(32'(n >= 125 && n < 140), 32'h1);
    // downward slew to the secondary crystal
    fin = 4'($urandom_range(7, 1));
    wr(CSS_SLEW_OFS, slewWord(fin, 3'h2, 1'b0, 1'b1));
    sw(CSS_SRC_POSC, CSS_SRC_SOSC, 1'b0);
    cyc(20);
    check({slewBusy, coreDivider, coreSrcSel}, {1'b1, 8'h02, CSS_SRC_POSC});
    srcReadyPin <= 8'h35;
    waitSrc(CSS_SRC_SOSC, 400);
    check({slewBusy, coreDivider}, {1'b0, 4'h0, fin});
    check(maxDiv, 32'(fin) * 2);
    wr(CSS_OSC_OFS, oscWord(CSS_SRC_SOSC, CSS_SRC_SOSC, 1'b0, 1'b0));
    cyc(2);
    check(soscRun, 1'b1);
    // upward slew to the PLL, held until lock
    fin = 4'($urandom_range(5, 1));
    wr(CSS_SLEW_OFS, slewWord(fin, 3'h3, 1'b1, 1'b0));
    srcReadyPin <= 8'h37;
    sw(CSS_SRC_SOSC, CSS_SRC_SPLL, 1'b0);
    cyc(40);
    check({slewBusy, coreSrcSel}, {1'b1, CSS_SRC_SOSC});
    check(srcEnable, 8'h12);
    pllLockPin <= 1'b1;
    waitSrc(CSS_SRC_SPLL, 50);
    check({slewBusy, coreDivider}, {1'b1, 8'(fin * 3)});
    n = 0;
    while (slewBusy !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    check(coreDivider, 32'(fin));
    check(soscRun, 1'b0);
    // request made asleep completes on wake
    wr(CSS_OSC_OFS, oscWord(CSS_SRC_SPLL, CSS_SRC_SPLL, 1'b1, 1'b0));
    wr(CSS_SLEW_OFS, slewWord(4'h1, 3'h0, 1'b0, 1'b0));
    inSleep <= 1'b1;
    sw(CSS_SRC_SPLL, CSS_SRC_LOW_POWER_RC_OSCILLATOR, 1'b1);
    cyc(50);
    check(coreSrcSel, CSS_SRC_SPLL);
    check(soscRun, 1'b1);
    @(posedge sys_clk);
    inSleep <= 1'b0;
    #1 check(cpuHold, 1'b1);
    waitSrc(CSS_SRC_LOW_POWER_RC_OSCILLATOR, 50);
    // the hold drops one cycle after completion
    cyc(1);
    check({cpuHold, coreSrcSel}, {1'b0, CSS_SRC_LOW_POWER_RC_OSCILLATOR});
    // hardware switch ignores the slew settings
    wr(CSS_SLEW_OFS, slewWord(4'h2, 3'h2, 1'b1, 1'b1));
    hwSw(CSS_SRC_FRC, 1'b0);
    waitSrc(CSS_SRC_FRC, 50);
    check({busySeen, coreSrcSel}, {1'b0, CSS_SRC_FRC});
    // two-speed start-up from the fast RC does slew: target 4 halves to 2
    hwSw(CSS_SRC_POSC, 1'b1);
    waitSrc(CSS_SRC_POSC, 200);
    cyc(10);
    check({busySeen, coreSrcSel, coreDivider}, {1'b1, CSS_SRC_POSC, 8'h02});
    summarize();
  end

  // hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("Error at %0t: run did not finish", $time);
    summarize();
  end
endmodule : testbench
